// >>> rtl/tmcs_timer.sv
`timescale 1ns/1ns
// How it works
// - Select bits for channels B..D: timer or PWM
// - Channel PWM bits only when select bit 1
// - Select bit 0 means triggered wave mode
// - Register C general or A buffer
// - Register D general or B buffer
// - Unassigned mode/status bits read as one
// - Run bit stops or starts the counter
// - Source field selects divided or fast clock
// - Code 101 counts external clock rising edges
// - Clear select: free run or clear on A
// - One output level bit per channel
// - Capture channels ignore level bits; only channel A also ignores clear
// - Capture on channel A makes the counter run freely
// - Four match flags plus overflow flag
// - Clear only by zero after reading one
// - Compare match sets channel flag
// - Chosen pin edge sets capture flag
// - Counter overflow sets overflow flag
module tmcs_timer (
	input  wire logic        ref_clk,     // 100 MHz clock
	input  wire logic        srst,        // Synchronous reset
	input  wire logic [9:0]  addr,        // Register address
	input  wire logic [7:0]  wdata,       // Write data
	input  wire logic        wr,          // Write strobe
	input  wire logic        rd,          // Read strobe
	input  wire logic        fast_internal_osc, // Fast oscillator tick
	input  wire logic        external_count_clock, // External count input
	input  wire logic [3:0]  chan_pin,    // Channel pins A..D
	output logic      [7:0]  rdata,       // Read data, next cycle
	output logic      [15:0] main_counter,// Counter value
	output logic      [3:0]  chan_pulse_mode, // Channel in PWM mode
	output logic             triggered_mode,  // Triggered wave mode
	output logic      [3:0]  chan_level   // Output level selects
);
	logic [7:0]  mode_q;
	logic [7:0]  ctrl_q;
	logic [4:0]  flags_q;
	logic [4:0]  seen_q;
	logic [15:0] gr_q [4];
	logic [7:0]  capcfg_q;
	logic [4:0]  pre_q;
	logic        ext_q;
	logic [3:0]  pin_q;
	logic        tick;
	logic        capture_any;
	logic [3:0]  match;
	logic [3:0]  cap_ev;
	logic        wrap;
	logic        clr_a;

	function automatic logic is_addr(input logic [9:0] a, input logic [9:0] b);
		is_addr = (a == b);
	endfunction

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mode_q <= tmcs_pkg::MODE_RST;
		end else if (wr && is_addr(addr, tmcs_pkg::ADDR_MODE)) begin
			mode_q <= (wdata & tmcs_pkg::MODE_WMASK) | tmcs_pkg::MODE_FIXED1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_q <= tmcs_pkg::CTRL1_RST;
		end else if (wr && is_addr(addr, tmcs_pkg::ADDR_CTRL1)) begin
			ctrl_q <= wdata;
		end
	end

	// Capture channel config: bit j = capture; edge select bits 2j+1:2j sit at the next address
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			capcfg_q <= tmcs_pkg::BYTE_ZERO;
		end else if (wr && is_addr(addr, tmcs_pkg::ADDR_CAPCFG)) begin
			capcfg_q <= wdata;
		end
	end

	logic [7:0] cap_edge_q;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cap_edge_q <= tmcs_pkg::BYTE_ZERO;
		end else if (wr && is_addr(addr, tmcs_pkg::ADDR_CAPCFG + 10'h001)) begin
			cap_edge_q <= wdata;
		end
	end

	logic [3:0] cap_en;
	assign cap_en = capcfg_q[3:0];

	// buffer writes to C/D land in C/D; transfer to A/B on clear
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_gr
			logic [9:0] base;
			logic        buf_load;
			logic [15:0] buf_val;
			assign base = tmcs_pkg::ADDR_GRA + 10'(2 * g);
			// Only A and B have a buffer partner, two slots up
			if (g < 2) begin : g_buf
				assign buf_load = clr_a & mode_q[tmcs_pkg::MODE_BFC + g];
				assign buf_val  = gr_q[g + 2];
			end else begin : g_nobuf
				assign buf_load = 1'b0;
				assign buf_val  = tmcs_pkg::CNT_ZERO;
			end
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					gr_q[g] <= tmcs_pkg::CNT_MAX;
				end else if (cap_ev[g]) begin
					gr_q[g] <= main_counter;
				end else if (buf_load) begin
					gr_q[g] <= buf_val;
				end else if (wr && is_addr(addr, base)) begin
					gr_q[g][15:8] <= wdata;
				end else if (wr && is_addr(addr, base + 10'h001)) begin
					gr_q[g][7:0] <= wdata;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Count source
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pre_q <= 5'h00;
			// Track the pins through reset so no false edge follows release
			ext_q <= external_count_clock;
			pin_q <= chan_pin;
		end else begin
			pre_q <= pre_q + 5'h01;
			ext_q <= external_count_clock;
			pin_q <= chan_pin;
		end
	end

	tmcs_pkg::tmcs_src_t src;
	assign src = tmcs_pkg::tmcs_src_t'(ctrl_q[tmcs_pkg::CTRL_SRC_L +: 3]);

	always_comb begin
		case (src)
			tmcs_pkg::SRC_DIV1:  tick = 1'b1;
			tmcs_pkg::SRC_DIV2:  tick = pre_q[0];
			tmcs_pkg::SRC_DIV4:  tick = &pre_q[1:0];
			tmcs_pkg::SRC_DIV8:  tick = &pre_q[2:0];
			tmcs_pkg::SRC_DIV32: tick = (pre_q == tmcs_pkg::PRE_MAX);
			tmcs_pkg::SRC_EXT:   tick = external_count_clock & ~ext_q;
			tmcs_pkg::SRC_OSC:   tick = fast_internal_osc;
			default:             tick = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------
	logic run;
	assign run = mode_q[tmcs_pkg::MODE_RUN];
	// Capture on A forces free-running counting
	assign capture_any = ~triggered_mode & cap_en[0];
	assign clr_a = run & tick & ctrl_q[tmcs_pkg::CTRL_COUNTER_CLEAR_SELECT] & ~capture_any
		& (main_counter == gr_q[0]);
	assign wrap = run & tick & ~clr_a & (main_counter == tmcs_pkg::CNT_MAX);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			main_counter <= tmcs_pkg::CNT_ZERO;
		end else if (wr && is_addr(addr, tmcs_pkg::ADDR_CNT)) begin
			main_counter[15:8] <= wdata;
		end else if (wr && is_addr(addr, tmcs_pkg::ADDR_CNT + 10'h001)) begin
			main_counter[7:0] <= wdata;
		end else if (clr_a) begin
			main_counter <= tmcs_pkg::CNT_ZERO;
		end else if (run && tick) begin
			main_counter <= main_counter + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// Events
	// ---------------------------------------------------------------
	generate
		for (g = 0; g < 4; g++) begin : g_ev
			logic rise;
			logic fall;
			logic cap;
			assign rise = chan_pin[g] & ~pin_q[g];
			assign fall = ~chan_pin[g] & pin_q[g];
			assign cap  = ~triggered_mode & cap_en[g];
			always_comb begin
				case (cap_edge_q[2*g +: 2])
					2'b00:   cap_ev[g] = cap & rise;
					2'b01:   cap_ev[g] = cap & fall;
					default: cap_ev[g] = cap & (rise | fall);
				endcase
			end
			assign match[g] = ~cap & run & tick & (main_counter == gr_q[g]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Status flags
	// ---------------------------------------------------------------
	logic [4:0] set_ev;
	logic [4:0] st_rd;
	logic       st_wr;
	assign set_ev = {wrap, cap_ev | match};
	assign st_wr = wr && is_addr(addr, tmcs_pkg::ADDR_STATUS);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			seen_q <= 5'h00;
		end else if (rd && is_addr(addr, tmcs_pkg::ADDR_STATUS)) begin
			seen_q <= flags_q;
		end else if (st_wr) begin
			seen_q <= 5'h00;
		end
	end

	assign st_rd = {wdata[tmcs_pkg::ST_OVF], wdata[3:0]};

	// Set beats clear; zero clears only bits seen as one
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flags_q <= 5'h00;
		end else if (st_wr) begin
			flags_q <= set_ev | (flags_q & ~(seen_q & ~st_rd));
		end else begin
			flags_q <= flags_q | set_ev;
		end
	end

	// ---------------------------------------------------------------
	// Read path and mode outputs
	// ---------------------------------------------------------------
	logic [7:0] rd_d;
	always_comb begin
		rd_d = tmcs_pkg::BYTE_ZERO;
		if (is_addr(addr, tmcs_pkg::ADDR_MODE)) begin
			rd_d = mode_q | tmcs_pkg::MODE_FIXED1;
		end else if (is_addr(addr, tmcs_pkg::ADDR_CTRL1)) begin
			rd_d = ctrl_q;
		end else if (is_addr(addr, tmcs_pkg::ADDR_STATUS)) begin
			rd_d = {flags_q[4], tmcs_pkg::STATUS_FIX1[6:4], flags_q[3:0]};
		end else if (is_addr(addr, tmcs_pkg::ADDR_CNT)) begin
			rd_d = main_counter[15:8];
		end else if (is_addr(addr, tmcs_pkg::ADDR_CNT + 10'h001)) begin
			rd_d = main_counter[7:0];
		end else if (is_addr(addr, tmcs_pkg::ADDR_CAPCFG)) begin
			rd_d = capcfg_q;
		end else if (is_addr(addr, tmcs_pkg::ADDR_CAPCFG + 10'h001)) begin
			rd_d = cap_edge_q;
		end
		// General registers: even byte high, odd byte low
		for (int i = 0; i < 4; i++) begin
			if (is_addr(addr, tmcs_pkg::ADDR_GRA + 10'(2 * i))) begin
				rd_d = gr_q[i][15:8];
			end else if (is_addr(addr, tmcs_pkg::ADDR_GRA + 10'(2 * i + 1))) begin
				rd_d = gr_q[i][7:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata <= tmcs_pkg::BYTE_ZERO;
		end else begin
			rdata <= rd ? rd_d : tmcs_pkg::BYTE_ZERO;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			triggered_mode  <= 1'b0;
			chan_pulse_mode <= 4'h0;
			chan_level      <= 4'h0;
		end else begin
			triggered_mode <= ~mode_q[tmcs_pkg::MODE_TW];
			chan_pulse_mode <= mode_q[tmcs_pkg::MODE_TW]
				? {mode_q[tmcs_pkg::MODE_CHAN_D_PULSE_SELECT], mode_q[tmcs_pkg::MODE_CHAN_C_PULSE_SELECT],
					mode_q[tmcs_pkg::MODE_CHAN_B_PULSE_SELECT], 1'b0}
				: 4'h0;
			chan_level <= ctrl_q[3:0] & ~cap_en;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_run_stop;
		@(posedge ref_clk) disable iff (srst)
		(!run && !wr) |=> (main_counter == $past(main_counter));
	endproperty
	a_run_stop: assert property (p_run_stop) else $error("counter moved while stopped");

	property p_status_ones;
		@(posedge ref_clk) disable iff (srst)
		(rd && addr == tmcs_pkg::ADDR_STATUS) |=> (rdata[6:4] == 3'b111);
	endproperty
	a_status_ones: assert property (p_status_ones) else $error("status spare bits not one");

	property p_ovf_set;
		@(posedge ref_clk) disable iff (srst)
		wrap |=> flags_q[4];
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

	property p_clear_a;
		@(posedge ref_clk) disable iff (srst)
		(clr_a && !wr) |=> (main_counter == tmcs_pkg::CNT_ZERO);
	endproperty
	a_clear_a: assert property (p_clear_a) else $error("no clear on match A");

	property p_free_run;
		@(posedge ref_clk) disable iff (srst)
		(capture_any && run && tick && !wr && main_counter == gr_q[0]
			&& main_counter != tmcs_pkg::CNT_MAX) |=> (main_counter == $past(main_counter) + 16'h0001);
	endproperty
	a_free_run: assert property (p_free_run) else $error("clear during capture");

	property p_keep_unseen;
		@(posedge ref_clk) disable iff (srst)
		(st_wr && !seen_q[0] && flags_q[0]) |=> flags_q[0];
	endproperty
	a_keep_unseen: assert property (p_keep_unseen) else $error("unseen flag cleared");

	property p_match_a;
		@(posedge ref_clk) disable iff (srst)
		match[0] |=> flags_q[0];
	endproperty
	a_match_a: assert property (p_match_a) else $error("match A flag not set");

	property p_triggered;
		@(posedge ref_clk) disable iff (srst)
		!mode_q[tmcs_pkg::MODE_TW] |=> (triggered_mode && chan_pulse_mode == 4'h0);
	endproperty
	a_triggered: assert property (p_triggered) else $error("pulse bits not ignored");
endmodule

// >>> rtl/tmcs_pkg.sv
package tmcs_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [9:0] ADDR_MODE    = 10'h120;
	localparam logic [9:0] ADDR_CTRL1   = 10'h121;
	localparam logic [9:0] ADDR_STATUS  = 10'h123;
	localparam logic [9:0] ADDR_GRA     = 10'h128;
	localparam logic [9:0] ADDR_GRB     = 10'h12a;
	localparam logic [9:0] ADDR_GRC     = 10'h12c;
	localparam logic [9:0] ADDR_GRD     = 10'h12e;
	localparam logic [9:0] ADDR_CAPCFG  = 10'h13c;
	localparam logic [9:0] ADDR_CNT     = 10'h126;

	localparam logic [7:0] MODE_RST     = 8'h48;
	localparam logic [7:0] CTRL1_RST    = 8'h00;
	localparam logic [7:0] STATUS_RST   = 8'h70;
	localparam logic [7:0] MODE_FIXED1  = 8'h40;
	localparam logic [7:0] STATUS_FIX1  = 8'h70;
	localparam logic [7:0] MODE_WMASK   = 8'hbf;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int MODE_CHAN_B_PULSE_SELECT  = 0;
	localparam int MODE_CHAN_C_PULSE_SELECT  = 1;
	localparam int MODE_CHAN_D_PULSE_SELECT  = 2;
	localparam int MODE_TW    = 3;
	localparam int MODE_BFC   = 4;
	localparam int MODE_BFD   = 5;
	localparam int MODE_RUN   = 7;
	localparam int CTRL_COUNTER_CLEAR_SELECT  = 7;
	localparam int CTRL_SRC_L = 4;
	localparam int ST_OVF     = 7;

	// ---------------------------------------------------------------
	// Count source codes and prescaler taps
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_DIV1  = 3'b000,
		SRC_DIV2  = 3'b001,
		SRC_DIV4  = 3'b010,
		SRC_DIV8  = 3'b011,
		SRC_DIV32 = 3'b100,
		SRC_EXT   = 3'b101,
		SRC_OSC   = 3'b110,
		SRC_BAD   = 3'b111
	} tmcs_src_t;

	localparam logic [4:0] PRE_MAX  = 5'h1f;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// >>> bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	// ----
	// Signals
	// ----
	logic        ref_clk;
	logic        srst;
	logic [9:0]  addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic        fast_internal_osc;
	logic        external_count_clock;
	logic [3:0]  chan_pin;
	logic [7:0]  rdata;
	logic [15:0] main_counter;
	logic [3:0]  chan_pulse_mode;
	logic        triggered_mode;
	logic [3:0]  chan_level;
	logic [7:0]  cyc_q;
	logic [15:0] c0;
	int          miscompares;
	int          checks;
	logic [15:0] exp_rate [8] = '{16'h0040, 16'h0020, 16'h0010, 16'h0008,
		16'h0002, 16'h0010, 16'h0020, 16'h0000};

	tmcs_timer u_dut (
		.ref_clk              (ref_clk),
		.srst                 (srst),
		.addr                 (addr),
		.wdata                (wdata),
		.wr                   (wr),
		.rd                   (rd),
		.fast_internal_osc    (fast_internal_osc),
		.external_count_clock (external_count_clock),
		.chan_pin             (chan_pin),
		.rdata                (rdata),
		.main_counter         (main_counter),
		.chan_pulse_mode      (chan_pulse_mode),
		.triggered_mode       (triggered_mode),
		.chan_level           (chan_level)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Oscillator enable every other cycle, external clock period of four
	always @(posedge ref_clk) begin
		cyc_q <= cyc_q + 8'h01;
		fast_internal_osc <= cyc_q[0];
		external_count_clock <= cyc_q[1];
	end

	// ----
	// Tasks
	// ----
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report;
		if (miscompares == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic do_reset;
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic chk_rd(input string name, input logic [9:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		check(name, {8'h00, d}, {8'h00, exp});
	endtask

	// Even address carries the high byte
	task automatic wr16(input logic [9:0] a, input logic [15:0] v);
		wr_reg(a, v[15:8]);
		wr_reg(a + 10'h001, v[7:0]);
	endtask

	task automatic chk16(input string name, input logic [9:0] a, input logic [15:0] exp);
		logic [7:0] hi;
		logic [7:0] lo;
		rd_reg(a, hi);
		rd_reg(a + 10'h001, lo);
		check(name, {hi, lo}, exp);
	endtask

	// Source is changed only while stopped
	task automatic rate(input logic [2:0] code, input logic [15:0] exp);
		wr_reg(tmcs_pkg::ADDR_CTRL1, {1'b0, code, 4'h0});
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h88);
		cycles(4);
		c0 = main_counter;
		cycles(64);
		check("count rate", main_counter - c0, exp);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h08);
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		repeat (100000) @(posedge ref_clk);
		miscompares++;
		final_report();
	end

	initial begin
		srst = 1'b1;
		addr = 10'h000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		cyc_q = 8'h00;
		fast_internal_osc = 1'b0;
		external_count_clock = 1'b0;
		chan_pin = 4'h2;
		miscompares = 0;
		checks = 0;
		do_reset();
		chk_rd("mode rst", tmcs_pkg::ADDR_MODE, 8'h48);
		chk_rd("ctrl rst", tmcs_pkg::ADDR_CTRL1, 8'h00);
		chk_rd("status rst", tmcs_pkg::ADDR_STATUS, 8'h70);
		chk_rd("unmapped", 10'h1ff, 8'h00);
		check("trig", 16'(triggered_mode), 16'h0000);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h07);
		chk_rd("mode b6", tmcs_pkg::ADDR_MODE, 8'h47);
		check("pulse off", 16'(chan_pulse_mode), 16'h0000);
		check("trig", 16'(triggered_mode), 16'h0001);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h0d);
		cycles(2);
		check("pulse on", 16'(chan_pulse_mode), 16'h000a);
		check("trig", 16'(triggered_mode), 16'h0000);
		wr_reg(tmcs_pkg::ADDR_STATUS, 8'h00);
		chk_rd("status fix", tmcs_pkg::ADDR_STATUS, 8'h70);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h08);
		wr_reg(tmcs_pkg::ADDR_CTRL1, 8'h0f);
		cycles(2);
		check("levels", 16'(chan_level), 16'h000f);
		c0 = main_counter;
		cycles(20);
		check("stopped", main_counter, c0);
		for (int i = 0; i < 8; i++) begin
			rate(3'(i), exp_rate[i]);
		end
		// Past the top: all four compares at ffff plus overflow
		wr_reg(tmcs_pkg::ADDR_CTRL1, 8'h00);
		wr16(tmcs_pkg::ADDR_CNT, 16'hfff0);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h88);
		cycles(30);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h08);
		wr_reg(tmcs_pkg::ADDR_STATUS, 8'h00);
		chk_rd("no read", tmcs_pkg::ADDR_STATUS, 8'hff);
		wr_reg(tmcs_pkg::ADDR_STATUS, 8'h7f);
		chk_rd("ovf clr", tmcs_pkg::ADDR_STATUS, 8'h7f);
		wr_reg(tmcs_pkg::ADDR_STATUS, 8'h00);
		chk_rd("all clr", tmcs_pkg::ADDR_STATUS, 8'h70);
		do_reset();
		wr16(tmcs_pkg::ADDR_GRA, 16'h0010);
		wr16(tmcs_pkg::ADDR_GRB, 16'h0005);
		wr16(tmcs_pkg::ADDR_GRC, 16'h0008);
		wr16(tmcs_pkg::ADDR_GRD, 16'h0007);
		wr_reg(tmcs_pkg::ADDR_CTRL1, 8'h80);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h88);
		cycles(50);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h08);
		check("clr on a", 16'(main_counter <= 16'h0010), 16'h0001);
		chk16("gra kept", tmcs_pkg::ADDR_GRA, 16'h0010);
		chk_rd("matches", tmcs_pkg::ADDR_STATUS, 8'h7f);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'hb8);
		cycles(60);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h38);
		chk16("gra buf", tmcs_pkg::ADDR_GRA, 16'h0008);
		chk16("grb buf", tmcs_pkg::ADDR_GRB, 16'h0007);
		do_reset();
		wr16(tmcs_pkg::ADDR_GRA, 16'h0010);
		wr_reg(tmcs_pkg::ADDR_CTRL1, 8'h8f);
		wr_reg(tmcs_pkg::ADDR_CAPCFG, 8'h03);
		wr_reg(tmcs_pkg::ADDR_CAPCFG + 10'h001, 8'h04);
		cycles(2);
		check("cap levels", 16'(chan_level), 16'h000c);
		wr_reg(tmcs_pkg::ADDR_MODE, 8'h88);
		cycles(40);
		check("cap free", 16'(main_counter > 16'h0020), 16'h0001);
		@(posedge ref_clk);
		chan_pin <= 4'h3;
		cycles(4);
		chk_rd("cap rise", tmcs_pkg::ADDR_STATUS, 8'h71);
		@(posedge ref_clk);
		chan_pin <= 4'h1;
		cycles(4);
		chk_rd("cap fall", tmcs_pkg::ADDR_STATUS, 8'h73);
		final_report();
	end
endmodule
